// *** rtl/spm_capability.sv ***
`timescale 1ns/1ps
`include "spm_defs.svh"

// What this block does
// - PM header low byte always reads capability id 01h.
// - PM next pointer resets 5Ch upstream, 4Ch downstream.
// - Header bits 18:16 read 011b, PM revision 1.2.
// - Bits 19 and 20 are zero and ignore writes.
// - Bit 21 reads 0 by default, no special initialization.
// - Auxiliary current bits 24:22 reset to 111b, 375 mA.
// - Bits 25 and 26 read 1 by default, D1 and D2 supported.
// - Bits 31:27 reset to all ones, events forwarded in all states.
// - Read-only defaults loadable by management bus, not by configuration writes.
// - Power state in bits 1:0, D0..D3hot, resets to D0.
// - Writing D0 from D3 triggers hot reset without downstream reset pin.
// - Bit 3 set skips internal reset on D3hot to D0.
// - Bit 8 read/write event enable, reset 0, gates event messages.
// - Bit 15 event status always reads 0.
// - Data byte bits 31:24 resets 00h, loadable by management bus.
// - Downstream ports return MSI capability id 05h.
// - MSI next pointer resets to 64h.

module spm_capability #(
    parameter bit UPSTREAM = 1'b0
) (
    input  wire logic                  clock,
    input  wire logic                  srst,
    input  wire spm_pkg::spm_cfg_req_t cfg_req,
    output logic                       cfg_ack,
    output logic [31:0]                cfg_rdata,
    input  wire logic                  dflt_load,
    input  wire spm_pkg::spm_defaults_t dflt_value,
    input  wire logic                  pme_request,
    output logic                       power_event_message,
    output logic [1:0]                 power_state,
    output logic                       hot_reset,
    output logic                       internal_reset,
    output logic                       downstream_reset_output
);
    import spm_pkg::*;

    typedef struct packed {
        spm_defaults_t dflt;
        logic [1:0]    pstate;
        logic          pme_en;
        logic [3:0]    data_sel;
        logic [31:0]   rdata;
        logic          ack;
        logic          pme_msg;
        logic          trig;
    } spm_state_t;

    spm_state_t st_ff;
    spm_state_t nxt_st;

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] read_reg(input spm_state_t s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == `SPM_OFF_PM_CAP) begin
            r[7:0]   = `SPM_PM_CAP_ID;
            r[15:8]  = UPSTREAM ? `SPM_PM_NEXT_UP : `SPM_PM_NEXT_DN;
            r[18:16] = `SPM_PM_REV;
            r[19]    = 1'b0;
            r[21]    = s.dflt.dev_spec_init;
            r[24:22] = s.dflt.aux_current;
            r[25]    = s.dflt.d1_support;
            r[26]    = s.dflt.d2_support;
            r[31:27] = s.dflt.pme_support;
        end else if (a == `SPM_OFF_PM_CSR) begin
            r[1:0]   = s.pstate;
            r[3]     = s.dflt.no_soft_reset;
            r[8]     = s.pme_en;
            r[12:9]  = s.data_sel;
            r[15]    = 1'b0;
            r[23:22] = 2'b00;
            r[31:24] = s.dflt.data_byte;
        end else if (a == `SPM_OFF_MSI_CAP && !UPSTREAM) begin
            r[7:0]   = `SPM_MSI_CAP_ID;
            r[15:8]  = `SPM_MSI_NEXT;
        end
        return r;
    endfunction

    logic [31:0] csr_new;
    logic        trig_hr;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.ack  = 1'b0;
        nxt_st.trig = 1'b0;
        csr_new     = merge(32'h0000_0000, cfg_req.wdata, cfg_req.byte_en);
        // Management loads win over nothing; host cannot touch these fields
        if (dflt_load) begin
            nxt_st.dflt = dflt_value;
        end
        if (cfg_req.valid) begin
            nxt_st.ack = 1'b1;
            if (cfg_req.write) begin
                if (cfg_req.addr == `SPM_OFF_PM_CSR) begin
                    if (cfg_req.byte_en[0]) begin
                        nxt_st.pstate = csr_new[1:0];
                        if (st_ff.pstate == `SPM_PS_D3 && csr_new[1:0] == `SPM_PS_D0) begin
                            nxt_st.trig = 1'b1;
                        end
                    end
                    if (cfg_req.byte_en[1]) begin
                        nxt_st.pme_en   = csr_new[8];
                        nxt_st.data_sel = csr_new[12:9];
                    end
                end
            end else begin
                nxt_st.rdata = read_reg(st_ff, cfg_req.addr);
            end
        end
        // Pulse only while enabled; status bit itself is not kept
        nxt_st.pme_msg = pme_request && st_ff.pme_en;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_ff.dflt.pme_support   <= `SPM_PME_SUP_RST;
            st_ff.dflt.d2_support    <= `SPM_D2_RST;
            st_ff.dflt.d1_support    <= `SPM_D1_RST;
            st_ff.dflt.aux_current   <= `SPM_AUX_RST;
            st_ff.dflt.dev_spec_init <= `SPM_DSI_RST;
            st_ff.dflt.no_soft_reset <= `SPM_NSR_RST;
            st_ff.dflt.data_byte     <= `SPM_DATA_RST;
            st_ff.pstate             <= `SPM_PS_D0;
            st_ff.pme_en             <= 1'b0;
            st_ff.data_sel           <= 4'h0;
            st_ff.rdata              <= 32'h0000_0000;
            st_ff.ack                <= 1'b0;
            st_ff.pme_msg            <= 1'b0;
            st_ff.trig               <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign trig_hr = st_ff.trig;

    spm_hot_reset u_hot_reset (
        .clock           (clock),
        .srst            (srst),
        .trigger         (trig_hr),
        .internal_enable (~st_ff.dflt.no_soft_reset),
        .hot_reset       (hot_reset),
        .internal_reset  (internal_reset)
    );

    assign cfg_ack                 = st_ff.ack;
    assign cfg_rdata               = st_ff.rdata;
    assign power_event_message     = st_ff.pme_msg;
    assign power_state             = st_ff.pstate;
    assign downstream_reset_output = 1'b0;
endmodule // spm_capability

// *** rtl/spm_defs.svh ***
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH

`define SPM_OFF_PM_CAP     8'h40
`define SPM_OFF_PM_CSR     8'h44
`define SPM_OFF_MSI_CAP    8'h4C

`define SPM_PM_CAP_ID      8'h01
`define SPM_PM_NEXT_UP     8'h5C
`define SPM_PM_NEXT_DN     8'h4C
`define SPM_PM_REV         3'b011
`define SPM_AUX_RST        3'b111
`define SPM_D1_RST         1'b1
`define SPM_D2_RST         1'b1
`define SPM_PME_SUP_RST    5'h1F
`define SPM_DSI_RST        1'b0
`define SPM_NSR_RST        1'b1
`define SPM_DATA_RST       8'h00
`define SPM_MSI_CAP_ID     8'h05
`define SPM_MSI_NEXT       8'h64

`define SPM_PS_D0          2'b00
`define SPM_PS_D3          2'b11

`define SPM_RST_PULSE      4'h8

`endif

// *** rtl/spm_hot_reset.sv ***
`timescale 1ns/1ps
`include "spm_defs.svh"

module spm_hot_reset (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic trigger,
    input  wire logic internal_enable,
    output logic      hot_reset,
    output logic      internal_reset
);
    import spm_pkg::*;

    typedef struct packed {
        spm_rst_state_t state;
        logic [3:0]     count;
        logic           hot;
        logic           internal;
    } spm_hr_state_t;

    spm_hr_state_t st_ff;
    spm_hr_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff.state)
            SPM_IDLE: begin
                if (trigger) begin
                    nxt_st.state    = SPM_RESETTING;
                    nxt_st.count    = `SPM_RST_PULSE;
                    nxt_st.hot      = 1'b1;
                    nxt_st.internal = internal_enable;
                end
            end
            SPM_RESETTING: begin
                nxt_st.count = st_ff.count - 4'h1;
                if (st_ff.count == 4'h1) begin
                    nxt_st.state    = SPM_IDLE;
                    nxt_st.hot      = 1'b0;
                    nxt_st.internal = 1'b0;
                end
            end
            default: nxt_st.state = SPM_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_ff <= '{state: SPM_IDLE, count: 4'h0, hot: 1'b0, internal: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hot_reset      = st_ff.hot;
    assign internal_reset = st_ff.internal;
endmodule // spm_hot_reset

// *** rtl/spm_pkg.sv ***
package spm_pkg;
    typedef struct packed {
        logic [4:0] pme_support;
        logic       d2_support;
        logic       d1_support;
        logic [2:0] aux_current;
        logic       dev_spec_init;
        logic       no_soft_reset;
        logic [7:0] data_byte;
    } spm_defaults_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } spm_cfg_req_t;

    typedef enum logic [1:0] {
        SPM_IDLE,
        SPM_RESETTING
    } spm_rst_state_t;
endpackage

// *** test/spm_capability_props.sv ***
`timescale 1ns/1ps
module spm_capability_props #(
    parameter bit UPSTREAM = 1'b0
) (
    input wire logic                   clock,
    input wire logic                   srst,
    input wire spm_pkg::spm_cfg_req_t  cfg_req,
    input wire logic                   cfg_ack,
    input wire logic [31:0]            cfg_rdata,
    input wire logic                   pme_request,
    input wire logic                   power_event_message,
    input wire logic [1:0]             power_state,
    input wire logic                   hot_reset,
    input wire logic                   internal_reset,
    input wire logic                   downstream_reset_output
);
    import spm_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_rd(a);
        cfg_req.valid && !cfg_req.write && cfg_req.addr == a;
    endsequence
    sequence s_wake;
        cfg_req.valid && cfg_req.write && cfg_req.addr == 8'h44 && cfg_req.byte_en[0]
            && cfg_req.wdata[1:0] == 2'b00 && power_state == 2'b11;
    endsequence
    a_ack_exact: assert property (cfg_req.valid |=> cfg_ack) else $error("ack missing");
    a_ack_quiet: assert property (!cfg_req.valid |=> !cfg_ack) else $error("spurious ack");
    a_pm_ident: assert property (s_rd(8'h40) |=> cfg_rdata[7:0] == 8'h01)
        else $error("bad pm id");
    a_pm_rev: assert property (s_rd(8'h40) |=> cfg_rdata[20:16] == 5'h03)
        else $error("bad pm revision");
    a_status_zero: assert property (s_rd(8'h44) |=> cfg_rdata[15] == 1'b0 && cfg_rdata[7:4] == 4'h0)
        else $error("status bit set");
    a_state_write: assert property (cfg_req.valid && cfg_req.write && cfg_req.addr == 8'h44
        && cfg_req.byte_en[0] |=> power_state == $past(cfg_req.wdata[1:0])) else $error("bad state");
    a_event_cause: assert property (power_event_message |-> $past(pme_request))
        else $error("event without cause");
    a_wake_reset: assert property (s_wake |-> ##[1:3] hot_reset) else $error("no hot reset");
    a_hot_pulse: assert property ($rose(hot_reset) |-> hot_reset[*8] ##1 !hot_reset)
        else $error("bad hot reset length");
    a_internal_pair: assert property (internal_reset |-> hot_reset) else $error("lone internal reset");
    a_pin_quiet: assert property (!downstream_reset_output) else $error("reset pin driven");
    a_msi_ident: assert property (s_rd(8'h4C) |=> UPSTREAM || cfg_rdata[15:0] == 16'h6405)
        else $error("bad msi header");
endmodule // spm_capability_props

bind spm_capability spm_capability_props #(.UPSTREAM(UPSTREAM)) props_u (.clock(clock), .srst(srst),
    .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .pme_request(pme_request),
    .power_event_message(power_event_message), .power_state(power_state), .hot_reset(hot_reset),
    .internal_reset(internal_reset), .downstream_reset_output(downstream_reset_output));

// *** test/spm_host_model.sv ***
`timescale 1ns/1ps
module spm_host_model (
    input  wire logic                  clock,
    output spm_pkg::spm_cfg_req_t      cfg_req,
    input  wire logic                  cfg_ack,
    input  wire logic [31:0]           cfg_rdata
);
    import spm_pkg::*;
    initial cfg_req = '0;
    task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd, output bit ok);
        ok = 1'b0;
        rd = 32'h0000_0000;
        cfg_req = '{1'b1, wr, a, be, wd};
        @(posedge clock);
        // Valid is one cycle; the edge above took the request
        #1 cfg_req.valid = 1'b0;
        // Stale data must not look valid
        cfg_req.wdata = ~wd;
        // Ack stands for one cycle only, so look before the next edge
        for (int i = 0; i < 4 && !ok; i++) begin
            if (cfg_ack === 1'b1) begin
                ok = 1'b1;
                rd = cfg_rdata;
            end else begin
                @(posedge clock);
                #1;
            end
        end
        // Idle edge so the next call never re-raises valid in this time step
        @(posedge clock);
        #1;
    endtask
endmodule // spm_host_model

// *** test/test_switch_port_pm_msi_capability.sv ***
`timescale 1ns/1ps
module test_switch_port_pm_msi_capability;
    import spm_pkg::*;
    logic          clock = 1'b0;
    logic          srst = 1'b1;
    logic          dflt_load = 1'b0;
    logic          pme_request = 1'b0;
    spm_defaults_t dflt_value = '0;
    spm_cfg_req_t  cfg_req;
    logic          cfg_ack, power_event_message, hot_reset, internal_reset, downstream_reset_output;
    logic [31:0]   cfg_rdata;
    logic [31:0]   up_rdata;
    logic [1:0]    power_state;
    int            num_errors = 0;
    int            cmp_count = 0;
    always #5 clock = ~clock;
    spm_host_model host_u (.clock(clock), .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
    spm_capability #(.UPSTREAM(1'b0)) dut_u (.clock(clock), .srst(srst), .cfg_req(cfg_req),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .dflt_load(dflt_load), .dflt_value(dflt_value),
        .pme_request(pme_request), .power_event_message(power_event_message), .power_state(power_state),
        .hot_reset(hot_reset), .internal_reset(internal_reset), .downstream_reset_output(downstream_reset_output));
    // Upstream twin shares the request bus; only its read data is watched
    spm_capability #(.UPSTREAM(1'b1)) dut_up_u (.clock(clock), .srst(srst), .cfg_req(cfg_req),
        .cfg_ack(), .cfg_rdata(up_rdata), .dflt_load(dflt_load), .dflt_value(dflt_value),
        .pme_request(pme_request), .power_event_message(), .power_state(), .hot_reset(),
        .internal_reset(), .downstream_reset_output());
    task automatic conclude();
        $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
                       input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] rd;
        bit          ok;
        host_u.access(wr, a, be, wd, rd, ok);
        if (!ok) begin
            num_errors++;
            conclude();
        end
        if (!wr) cmp(rd & m, exp);
    endtask
    // Counts pulse width over a fixed window, long enough for the latency
    task automatic pulse(input logic [31:0] exp_int);
        int hi, ih, dn;
        hi = 0;
        ih = 0;
        dn = 0;
        // Sample first: the pulse is already up when the write returns
        for (int i = 0; i < 24; i++) begin
            hi += (hot_reset === 1'b1);
            ih += (internal_reset === 1'b1);
            dn += (downstream_reset_output !== 1'b0);
            @(posedge clock);
            #1;
        end
        cmp(hi, 8);
        cmp(ih, exp_int);
        cmp(dn, 0);
    endtask
    initial begin
        repeat (4) @(posedge clock);
        #1 srst = 1'b0;
        pme_request = 1'b1;
        repeat (2) @(posedge clock);
        #1 cmp(power_event_message, 0);
        pme_request = 1'b0;
        acc(0, 8'h40, 4'hF, 0, 32'hFFC3_4C01, '1);
        cmp(up_rdata, 32'hFFC3_5C01);
        acc(0, 8'h44, 4'hF, 0, 32'h0000_0008, '1);
        acc(0, 8'h4C, 4'hF, 0, 32'h0000_6405, 32'h0000_FFFF);
        cmp(up_rdata, 32'h0000_0000);
        acc(0, 8'h80, 4'hF, 0, 32'h0000_0000, '1);
        acc(1, 8'h40, 4'hF, '1, 0, 0);
        acc(0, 8'h40, 4'hF, 0, 32'hFFC3_4C01, '1);
        acc(1, 8'h44, 4'hF, '1, 0, 0);
        acc(0, 8'h44, 4'hF, 0, 32'h0000_1F0B, '1);
        pme_request = 1'b1;
        repeat (2) @(posedge clock);
        #1 cmp(power_event_message, 1);
        acc(1, 8'h44, 4'h2, 0, 0, 0);
        repeat (2) @(posedge clock);
        #1 cmp(power_event_message, 0);
        pme_request = 1'b0;
        acc(1, 8'h44, 4'h1, 0, 0, 0);
        pulse(0);
        cmp(power_state, 0);
        dflt_value = '{5'h0A, 1'b1, 1'b0, 3'b010, 1'b1, 1'b0, 8'h5A};
        dflt_load = 1'b1;
        @(posedge clock);
        #1 dflt_load = 1'b0;
        acc(0, 8'h40, 4'hF, 0, 32'h54A3_4C01, '1);
        acc(0, 8'h44, 4'hF, 0, 32'h5A00_0000, '1);
        acc(1, 8'h44, 4'h1, 32'h0000_0003, 0, 0);
        acc(1, 8'h44, 4'h1, 0, 0, 0);
        pulse(8);
        conclude();
    end
endmodule // test_switch_port_pm_msi_capability
